// ### common/thermal_alert_pkg.sv
// Shared constants for the thermal alert and status unit
package thermal_alert_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_STATUS_PRI = 8'h41;
    localparam logic [7:0] ADDR_STATUS_SEC = 8'h42;
    localparam logic [7:0] ADDR_MASK_PRI = 8'h74;
    localparam logic [7:0] ADDR_MASK_SEC = 8'h75;
    localparam logic [7:0] ADDR_PIN_BOOST = 8'h78;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h7d;
    // Primary status fields; measurement channel codes equal these positions
    localparam int B1_SUMMARY = 7;
    localparam int B1_REMOTE_TWO = 6;
    localparam int B1_LOCAL = 5;
    localparam int B1_REMOTE_ONE = 4;
    localparam int B1_MAIN_SUPPLY = 2;
    localparam int B1_PROC_SUPPLY = 1;
    localparam logic [7:0] PRI_USED = 8'h76;
    // Secondary status fields
    localparam int B2_DIODE_TWO = 7;
    localparam int B2_DIODE_ONE = 6;
    localparam int B2_FOURTH = 5;
    localparam int B2_THIRD_TACH_STALL = 4;
    localparam int B2_SECOND_TACH_STALL = 3;
    localparam int B2_FIRST_TACH_STALL = 2;
    localparam int B2_OVERTEMP = 1;
    localparam int B2_LATCH = 0;
    // Configuration fields
    localparam int CFG3_ALERT_EN = 0;
    localparam int CFG3_THERMAL_EN = 1;
    localparam int CFG3_BOOST = 2;
    localparam int CFG4_LATCH_NO_FAN = 2;
    // Shared pin function codes
    localparam logic [1:0] FUNC_TACH = 2'b01;
    localparam logic [1:0] FUNC_THERMAL = 2'b00;
    localparam logic [1:0] FUNC_ALERT = 2'b11;
    localparam logic [1:0] FUNC_GPIO = 2'b10;
    // Values after reset
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_PIN_BOOST = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC = 8'h01;
    // Latch limits in whole degrees: 136 and 100
    localparam logic [7:0] LATCH_LIMIT_REMOTE_TWO = 8'h88;
    localparam logic [7:0] LATCH_LIMIT_REMOTE_ONE = 8'h64;
endpackage : thermal_alert_pkg

// ### core/thermal_alert_status_unit.sv
// Limit status registers, alert output, shared pin function and boost
//
// Notes on behaviour
// - Out-of-limit comparison result sets the channel status bit, else bit may clear.
// - High limit uses greater than; low limit uses less than or equal.
// - Primary bit 7 reads one whenever any secondary status bit is set.
// - All status bits except overtemperature stay set until read.
// - Read clears a bit only if its condition has already ended.
// - Overtemperature bit and its alert follow the live condition.
// - Mask bits block only the alert; status bits still set.
// - Alert stays low while unmasked reading out of limit, then until read.
// - Primary bits: 6 remote two, 5 local, 4 remote one, 2 main, 1 processor.
// - Secondary bits: 7,6 diodes, 4..2 fans three to one, 1 overtemperature.
// - Secondary bit 5 is fan four, or timer limit when timer in use.
// - Primary mask shares status positions; one suppresses that channel.
// - With secondary mask all ones, primary mask bit 7 gates secondary alert.
// - Secondary mask ones suppress diode, fan, thermal and overtemperature alerts.
// - Alert function off after reset; bit 0 of 0x78 enables alternate pin.
// - Bits 1:0 of 0x7D pick tach, thermal, alert or GPIO for shared pin.
// - Thermal function acts only once bit 1 of 0x78 is also set.
// - Boost set drives all fans full while thermal input held low.
// - Boost applies only to fans already running.
// - Latch output sets when remote exceeds limit by a quarter degree.
// - Latch releases when temperature below limit and latch status cleared.
// - Latch limits reset to 136 for remote two, 100 for remote one.
`timescale 1ns/1ns
module thermal_alert_status_unit
    import thermal_alert_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_meas_valid,
    input wire logic [2:0] i_meas_chan,
    input wire logic [7:0] i_meas_value,
    input wire logic [7:0] i_meas_high,
    input wire logic [7:0] i_meas_low,
    input wire logic [1:0] i_diode_fault,
    input wire logic [3:0] i_tach_stall,
    input wire logic i_timer_limit_hit,
    input wire logic i_overtemp,
    input wire logic i_thermal_pin,
    input wire logic i_fans_running,
    input wire logic i_latch_sel_two,
    input wire logic [9:0] i_latch_temp,
    output logic [7:0] o_reg_rdata,
    output logic o_alert_out,
    output logic o_alt_pin_oe_n,
    output logic o_shared_pin_oe_n,
    output logic [1:0] o_shared_func,
    output logic o_fan_boost,
    output logic o_fan_full,
    output logic o_thermal_latch_output
);

    logic [7:0] status_pri;
    logic [7:0] status_sec;
    logic [7:0] mask_pri;
    logic [7:0] mask_sec;
    logic [7:0] pin_boost_cfg;
    logic [7:0] pin_func_cfg;
    logic [7:0] live_pri;
    logic [7:0] cond_sec;
    logic [7:0] next_status_pri;
    logic [7:0] next_status_sec;
    logic [7:0] read_pri;
    logic [7:0] read_sec;
    logic [2:0] thermal_sync;
    logic thermal_level;
    logic timer_in_use;
    logic latch_over;
    logic latch_under;
    logic [9:0] latch_limit_q;
    logic alert_any;
    logic alert_pri;
    logic alert_sec;
    logic wr_hit;
    logic rd_pri;
    logic rd_sec;
    logic sec_any;

    ////////////////////////////////////////////////////////////////////////
    // Limit comparison
    ////////////////////////////////////////////////////////////////////////

    // Last comparison result per analog channel
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            live_pri <= 8'h00;
        end else if (i_meas_valid && PRI_USED[i_meas_chan]) begin
            live_pri[i_meas_chan] <= (i_meas_value > i_meas_high) ||
                (i_meas_value <= i_meas_low);
        end
    end

    // Fourth flag source follows thermal timer use
    assign timer_in_use = (pin_func_cfg[1:0] == FUNC_THERMAL) &&
        pin_boost_cfg[CFG3_THERMAL_EN];

    // Secondary live conditions
    always_comb begin
        cond_sec = 8'h00;
        cond_sec[B2_DIODE_TWO] = i_diode_fault[1];
        cond_sec[B2_DIODE_ONE] = i_diode_fault[0];
        cond_sec[B2_FOURTH] = timer_in_use ? i_timer_limit_hit : i_tach_stall[3];
        cond_sec[B2_THIRD_TACH_STALL] = i_tach_stall[2];
        cond_sec[B2_SECOND_TACH_STALL] = i_tach_stall[1];
        cond_sec[B2_FIRST_TACH_STALL] = i_tach_stall[0];
        cond_sec[B2_OVERTEMP] = i_overtemp;
        cond_sec[B2_LATCH] = latch_over;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status registers
    ////////////////////////////////////////////////////////////////////////

    assign rd_pri = i_reg_rd && (i_reg_addr == ADDR_STATUS_PRI);
    assign rd_sec = i_reg_rd && (i_reg_addr == ADDR_STATUS_SEC);

    // Sticky update; a set in the read cycle wins over the clear
    always_comb begin
        next_status_pri = status_pri;
        next_status_sec = status_sec;
        if (rd_pri) begin
            next_status_pri = status_pri & live_pri;
        end
        if (rd_sec) begin
            next_status_sec = status_sec & cond_sec;
        end
        next_status_pri = (next_status_pri | live_pri) & PRI_USED;
        next_status_sec = next_status_sec | cond_sec;
        next_status_sec[B2_OVERTEMP] = i_overtemp;
    end

    // Status flops
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            status_pri <= 8'h00;
            status_sec <= 8'h00;
        end else begin
            status_pri <= next_status_pri;
            status_sec <= next_status_sec;
        end
    end

    // Readback views with summary bit
    always_comb begin
        read_pri = status_pri;
        read_pri[B1_SUMMARY] = |status_sec;
        read_sec = status_sec;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port
    ////////////////////////////////////////////////////////////////////////

    assign wr_hit = i_reg_wr;

    // Writable configuration and masks
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            mask_pri <= RST_MASK;
            mask_sec <= RST_MASK;
            pin_boost_cfg <= RST_PIN_BOOST;
            pin_func_cfg <= RST_PIN_FUNC;
        end else if (wr_hit) begin
            unique case (i_reg_addr)
                ADDR_MASK_PRI: mask_pri <= i_reg_wdata;
                ADDR_MASK_SEC: mask_sec <= i_reg_wdata;
                ADDR_PIN_BOOST: pin_boost_cfg <= i_reg_wdata;
                ADDR_PIN_FUNC: pin_func_cfg <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Registered read data, zero for unmapped offsets
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_STATUS_PRI: o_reg_rdata <= read_pri;
                ADDR_STATUS_SEC: o_reg_rdata <= read_sec;
                ADDR_MASK_PRI: o_reg_rdata <= mask_pri;
                ADDR_MASK_SEC: o_reg_rdata <= mask_sec;
                ADDR_PIN_BOOST: o_reg_rdata <= pin_boost_cfg;
                ADDR_PIN_FUNC: o_reg_rdata <= pin_func_cfg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alert output
    ////////////////////////////////////////////////////////////////////////

    // Unmasked sources; overtemperature bit is live so its alert self-clears
    assign alert_pri = |(status_pri & ~mask_pri & PRI_USED);
    assign alert_sec = (&mask_sec[7:1]) ?
        ((|status_sec[7:1]) && !mask_pri[B1_SUMMARY]) :
        (|(status_sec[7:1] & ~mask_sec[7:1]));
    assign alert_any = alert_pri || alert_sec;

    assign o_shared_func = pin_func_cfg[1:0];
    assign o_alert_out = alert_any;
    // Open-drain enables, low while pulling the pin low
    assign o_alt_pin_oe_n = !(alert_any && pin_boost_cfg[CFG3_ALERT_EN]);
    assign o_shared_pin_oe_n = !(alert_any && (pin_func_cfg[1:0] == FUNC_ALERT));

    ////////////////////////////////////////////////////////////////////////
    // Thermal input and boost
    ////////////////////////////////////////////////////////////////////////

    // Three-stage synchroniser, level accepted when last two agree
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            thermal_sync <= 3'h7;
            thermal_level <= 1'b1;
        end else begin
            thermal_sync <= {thermal_sync[1:0], i_thermal_pin};
            if (thermal_sync[1] == thermal_sync[2]) begin
                thermal_level <= thermal_sync[2];
            end
        end
    end

    // Full duty while thermal input low, only for running fans
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_fan_boost <= 1'b0;
        end else begin
            o_fan_boost <= timer_in_use && pin_boost_cfg[CFG3_BOOST] &&
                !thermal_level && i_fans_running;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latching thermal output
    ////////////////////////////////////////////////////////////////////////

    // Limit in quarter degrees for the selected remote channel
    assign latch_limit_q = {i_latch_sel_two ? LATCH_LIMIT_REMOTE_TWO :
        LATCH_LIMIT_REMOTE_ONE, 2'b00};
    assign latch_over = i_latch_temp > latch_limit_q;
    assign latch_under = i_latch_temp < latch_limit_q;

    // Latch holds until cool and its status bit has been cleared
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_thermal_latch_output <= 1'b0;
        end else if (latch_over) begin
            o_thermal_latch_output <= 1'b1;
        end else if (latch_under && !status_sec[B2_LATCH]) begin
            o_thermal_latch_output <= 1'b0;
        end
    end

    // Full fan speed from the latch unless disabled
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_fan_full <= 1'b0;
        end else begin
            o_fan_full <= (o_thermal_latch_output &&
                !pin_func_cfg[CFG4_LATCH_NO_FAN]) || o_fan_boost;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    // Independent view of the secondary flags for the summary check
    assign sec_any = status_sec != 8'h00;

    // Status, read, mask, alert, boost and latch behaviour
    AST_SUMMARY_BIT: assert property (
        i_reg_rd && i_reg_addr == ADDR_STATUS_PRI |=> o_reg_rdata[7] == $past(sec_any))
        else $error("summary bit wrong");
    AST_STICKY_HOLD: assert property (
        status_pri[B1_LOCAL] && !rd_pri |=> status_pri[B1_LOCAL])
        else $error("primary bit lost without read");
    AST_READ_KEEPS_LIVE: assert property (
        rd_sec && cond_sec[B2_FIRST_TACH_STALL] |=> status_sec[B2_FIRST_TACH_STALL])
        else $error("read cleared live condition");
    AST_READ_CLEARS: assert property (
        rd_pri && !live_pri[B1_REMOTE_ONE] |=> !status_pri[B1_REMOTE_ONE])
        else $error("read did not clear ended bit");
    AST_OVT_LIVE: assert property (
        !i_overtemp |=> !status_sec[B2_OVERTEMP])
        else $error("overtemperature bit not self cleared");
    AST_MASK_STATUS: assert property (
        i_meas_valid && i_meas_chan == 3'h6 && i_meas_value > i_meas_high
        |=> ##1 status_pri[B1_REMOTE_TWO])
        else $error("masked source did not set status");
    AST_ALERT_HOLD: assert property (
        status_pri[B1_PROC_SUPPLY] && !mask_pri[B1_PROC_SUPPLY] |-> o_alert_out)
        else $error("alert released with unmasked bit set");
    AST_SUMMARY_MASK: assert property (
        (&mask_sec[7:1]) && mask_pri[7] && status_pri == 8'h00 |-> !o_alert_out)
        else $error("summary mask ignored");
    AST_ALERT_PIN: assert property (
        !pin_boost_cfg[CFG3_ALERT_EN] |-> o_alt_pin_oe_n)
        else $error("alternate pin driven while disabled");
    AST_BOOST: assert property (
        o_fan_boost |-> $past(pin_boost_cfg[CFG3_BOOST]) && $past(i_fans_running))
        else $error("boost without enable or running fans");
    AST_LATCH_SET: assert property (
        latch_over |=> o_thermal_latch_output ##1 o_fan_full || pin_func_cfg[2])
        else $error("latch did not assert");
    AST_LATCH_HOLD: assert property (
        o_thermal_latch_output && status_sec[B2_LATCH] |=> o_thermal_latch_output)
        else $error("latch released with status set");

    // Comparison direction, unused bits and flag sources
    AST_HIGH_STRICT: assert property (
        i_meas_valid && i_meas_chan == 3'h5 && i_meas_value == i_meas_high &&
        i_meas_value > i_meas_low |=> !live_pri[B1_LOCAL])
        else $error("value at high limit flagged");
    AST_LOW_SETS: assert property (
        i_meas_valid && i_meas_chan == 3'h1 && i_meas_value <= i_meas_low
        |=> ##1 status_pri[B1_PROC_SUPPLY])
        else $error("low limit hit not flagged");
    AST_UNUSED_BITS: assert property (
        !status_pri[3] && !status_pri[0])
        else $error("unused primary bit set");
    AST_FOURTH_TIMER: assert property (
        timer_in_use && i_timer_limit_hit |=> status_sec[B2_FOURTH])
        else $error("timer limit not flagged");
    AST_OVT_SET: assert property (
        i_overtemp |=> status_sec[B2_OVERTEMP])
        else $error("overtemperature bit not set");
    AST_LATCH_STATUS: assert property (
        latch_over |=> status_sec[B2_LATCH])
        else $error("latch status not set");

    // Pin drive, boost qualifiers and latch fan control
    AST_ALT_PIN_DRIVE: assert property (
        pin_boost_cfg[CFG3_ALERT_EN] && o_alert_out |-> !o_alt_pin_oe_n)
        else $error("enabled alternate pin not driven");
    AST_SHARED_PIN: assert property (
        pin_func_cfg[1:0] != FUNC_ALERT |-> o_shared_pin_oe_n)
        else $error("shared pin driven outside alert function");
    AST_THERMAL_GATE: assert property (
        !pin_boost_cfg[CFG3_THERMAL_EN] |=> !o_fan_boost)
        else $error("boost without thermal enable");
    AST_IDLE_FANS: assert property (
        !i_fans_running |=> !o_fan_boost)
        else $error("boost on stopped fans");
    AST_LATCH_NO_FAN: assert property (
        pin_func_cfg[CFG4_LATCH_NO_FAN] && !o_fan_boost |=> !o_fan_full)
        else $error("latch forced fans while disabled");
    AST_LATCH_KEEP: assert property (
        o_thermal_latch_output && !latch_under |=> o_thermal_latch_output)
        else $error("latch released while hot");

    // Main scenarios reached
    COV_ALERT: cover property (!o_alert_out ##1 o_alert_out ##[1:20] !o_alert_out);
    COV_BOOST: cover property ($rose(o_fan_boost));
    COV_LATCH: cover property ($rose(o_thermal_latch_output) ##[1:50] $fell(o_thermal_latch_output));
    COV_READ_CLEAR: cover property (rd_sec && status_sec[B2_SECOND_TACH_STALL] && !cond_sec[B2_SECOND_TACH_STALL]);
    COV_TIMER_FLAG: cover property (timer_in_use && i_timer_limit_hit);

endmodule : thermal_alert_status_unit

// ### bench/thermal_agent.sv
// External agent that pulls the shared thermal input low on request
`timescale 1ns/1ns
module thermal_agent (
    input wire logic i_hold,
    output logic o_thermal_pin
);
    logic link_clock = 1'b0;
    // Free link clock, phase unrelated to the core clock
    initial begin
        #13;
        forever #40 link_clock = ~link_clock;
    end
    // Line idles high through its pull-up, low only while held
    initial o_thermal_pin = 1'b1;
    always @(posedge link_clock) begin
        o_thermal_pin <= ~i_hold;
    end
endmodule : thermal_agent

// ### bench/thermal_alert_status_unit_bench.sv
// Self-checking bench for the thermal alert and status unit
`timescale 1ns/1ns
module thermal_alert_status_unit_bench;
    import thermal_alert_pkg::*;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_meas_valid = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_meas_value = 8'h00;
    logic [7:0] i_meas_high = 8'h00, i_meas_low = 8'h00, o_reg_rdata, r, h;
    logic [2:0] i_meas_chan = 3'h0;
    logic [1:0] i_diode_fault = 2'h0, o_shared_func;
    logic [3:0] i_tach_stall = 4'h0;
    logic i_overtemp = 1'b0, i_thermal_pin, i_fans_running = 1'b0, i_latch_sel_two = 1'b0, hold = 1'b0;
    logic [9:0] i_latch_temp = 10'h000;
    logic o_alert_out, o_alt_pin_oe_n, o_shared_pin_oe_n, o_fan_boost, o_fan_full;
    logic o_thermal_latch_output, latched = 1'b0, timer_hit = 1'b0;
    logic [7:0] st1 = 8'h00, st2 = 8'h00, live1 = 8'h00, m1 = RST_MASK, m2 = RST_MASK;
    logic [7:0] cfg3 = RST_PIN_BOOST, cfg4 = RST_PIN_FUNC;
    logic [7:0] regs [8] = '{ADDR_STATUS_PRI, ADDR_STATUS_SEC, ADDR_MASK_PRI, ADDR_MASK_SEC,
        ADDR_PIN_BOOST, ADDR_PIN_FUNC, 8'h43, 8'hff};
    logic [2:0] chans [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    integer seed = 32'h9a9f297f, mismatches = 0, checked = 0, cycles = 0;

    thermal_alert_status_unit dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .i_meas_valid(i_meas_valid), .i_meas_chan(i_meas_chan),
        .i_meas_value(i_meas_value), .i_meas_high(i_meas_high), .i_meas_low(i_meas_low),
        .i_diode_fault(i_diode_fault), .i_tach_stall(i_tach_stall), .i_timer_limit_hit(timer_hit),
        .i_overtemp(i_overtemp), .i_thermal_pin(i_thermal_pin), .i_fans_running(i_fans_running),
        .i_latch_sel_two(i_latch_sel_two), .i_latch_temp(i_latch_temp), .o_reg_rdata(o_reg_rdata),
        .o_alert_out(o_alert_out), .o_alt_pin_oe_n(o_alt_pin_oe_n),
        .o_shared_pin_oe_n(o_shared_pin_oe_n), .o_shared_func(o_shared_func),
        .o_fan_boost(o_fan_boost), .o_fan_full(o_fan_full),
        .o_thermal_latch_output(o_thermal_latch_output));
    thermal_agent agent (.i_hold(hold), .o_thermal_pin(i_thermal_pin));

    // Core clock and hang guard
    always #2 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference model
    function automatic logic [7:0] lim();
        return i_latch_sel_two ? LATCH_LIMIT_REMOTE_TWO : LATCH_LIMIT_REMOTE_ONE;
    endfunction : lim
    function automatic logic [7:0] sec_now();
        return {st2[7:2], i_overtemp, st2[0]};
    endfunction : sec_now
    function automatic logic [7:0] cond2();
        logic t;
        t = cfg4[1:0] == FUNC_THERMAL && cfg3[1];
        return {i_diode_fault, t ? timer_hit : i_tach_stall[3], i_tach_stall[2:0], 2'b00};
    endfunction : cond2
    function automatic logic alert_exp();
        logic [7:0] s;
        s = sec_now() & 8'hfe;
        if (m2[7:1] == 7'h7f) return (|(st1 & 8'h76 & ~m1)) | ((|s) & ~m1[7]);
        return (|(st1 & 8'h76 & ~m1)) | (|(s & ~m2));
    endfunction : alert_exp
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic settle(input int n);
        repeat (n) @(negedge i_clock);
        st2 = st2 | cond2();
        if (i_latch_temp > {lim(), 2'b00}) begin
            st2[0] = 1'b1;
            latched = 1'b1;
        end
        if (i_latch_temp < {lim(), 2'b00} && !st2[0]) latched = 1'b0;
    endtask : settle
    task automatic chk_pins();
        logic a;
        a = alert_exp();
        compare("alert", {7'h0, a}, {7'h0, o_alert_out});
        compare("alt pin", {7'h0, ~(cfg3[0] & a)}, {7'h0, o_alt_pin_oe_n});
        compare("shared pin", {7'h0, ~(cfg4[1:0] == FUNC_ALERT && a)}, {7'h0, o_shared_pin_oe_n});
        compare("function", {6'h0, cfg4[1:0]}, {6'h0, o_shared_func});
        compare("latch", {7'h0, latched}, {7'h0, o_thermal_latch_output});
    endtask : chk_pins

    ////////////////////////////////////////////////////////////////////////////
    // Register and measurement drivers
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_reg_addr = addr;
        i_reg_wdata = data;
        i_reg_wr = 1'b1;
        @(negedge i_clock);
        i_reg_wr = 1'b0;
        case (addr)
            ADDR_MASK_PRI: m1 = data;
            ADDR_MASK_SEC: m2 = data;
            ADDR_PIN_BOOST: cfg3 = data;
            ADDR_PIN_FUNC: cfg4 = data;
            default: ;
        endcase
        @(negedge i_clock);
    endtask : wr
    task automatic rd_chk(input logic [7:0] addr);
        logic [7:0] exp;
        case (addr)
            ADDR_STATUS_PRI: exp = {|sec_now(), st1[6:0] & 7'h76};
            ADDR_STATUS_SEC: exp = sec_now();
            ADDR_MASK_PRI: exp = m1;
            ADDR_MASK_SEC: exp = m2;
            ADDR_PIN_BOOST: exp = cfg3;
            ADDR_PIN_FUNC: exp = cfg4;
            default: exp = 8'h00;
        endcase
        i_reg_addr = addr;
        i_reg_rd = 1'b1;
        @(negedge i_clock);
        i_reg_rd = 1'b0;
        compare("read data", exp, o_reg_rdata);
        if (addr == ADDR_STATUS_PRI) st1 = st1 & live1;
        if (addr == ADDR_STATUS_SEC) begin
            st2 = st2 & (cond2() | {7'h0, i_latch_temp > {lim(), 2'b00}});
        end
        @(negedge i_clock);
    endtask : rd_chk
    task automatic meas(input logic [2:0] ch, input logic [7:0] v, input logic [7:0] l);
        i_meas_chan = ch;
        i_meas_value = v;
        i_meas_high = h;
        i_meas_low = l;
        i_meas_valid = 1'b1;
        @(negedge i_clock);
        i_meas_valid = 1'b0;
        live1[ch] = (v > h) || (v <= l);
        st1[ch] = st1[ch] | live1[ch];
        settle(2);
    endtask : meas
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(negedge i_clock);
        i_sys_rst = 1'b0;
        wr(ADDR_STATUS_SEC, 8'hff);
        foreach (regs[k]) rd_chk(regs[k]);
        chk_pins();
        $display("test reset done");
        foreach (chans[k]) begin
            h = 8'h40 | 8'($random(seed) & 32'h3f);
            meas(chans[k], h, 8'h10);
            chk_pins();
            meas(chans[k], h + 8'h01, 8'h10);
            chk_pins();
            meas(chans[k], 8'h11, 8'h10);
            rd_chk(ADDR_STATUS_PRI);
            rd_chk(ADDR_STATUS_PRI);
            meas(chans[k], 8'h10, 8'h10);
            rd_chk(ADDR_STATUS_PRI);
            meas(chans[k], 8'h11, 8'h10);
            rd_chk(ADDR_STATUS_PRI);
        end
        meas(3'h3, 8'hff, 8'h10);
        rd_chk(ADDR_STATUS_PRI);
        $display("test primary done");
        for (int b = 0; b < 6; b++) begin
            {i_diode_fault, i_tach_stall} = 6'h1 << b;
            settle(2);
            rd_chk(ADDR_STATUS_PRI);
            {i_diode_fault, i_tach_stall} = 6'h0;
            settle(2);
            chk_pins();
            rd_chk(ADDR_STATUS_SEC);
            rd_chk(ADDR_STATUS_SEC);
        end
        i_overtemp = 1'b1;
        settle(2);
        rd_chk(ADDR_STATUS_SEC);
        chk_pins();
        i_overtemp = 1'b0;
        settle(2);
        chk_pins();
        rd_chk(ADDR_STATUS_PRI);
        $display("test secondary done");
        i_tach_stall = 4'h9;
        i_overtemp = 1'b1;
        meas(3'h5, 8'hff, 8'h10);
        for (int k = 0; k < 16; k++) begin
            r = 8'($random(seed));
            wr(ADDR_MASK_PRI, r);
            wr(ADDR_MASK_SEC, (k < 4) ? (r | 8'hfe) : 8'($random(seed)));
            wr(ADDR_PIN_FUNC, 8'(k % 4));
            wr(ADDR_PIN_BOOST, 8'(k / 4 % 2));
            chk_pins();
            rd_chk(ADDR_MASK_SEC);
        end
        i_tach_stall = 4'h0;
        i_overtemp = 1'b0;
        meas(3'h5, 8'h20, 8'h10);
        rd_chk(ADDR_STATUS_PRI);
        rd_chk(ADDR_STATUS_SEC);
        i_diode_fault = 2'h2;
        settle(2);
        rd_chk(ADDR_STATUS_SEC);
        wr(ADDR_MASK_SEC, 8'h80);
        i_diode_fault = 2'h0;
        settle(2);
        chk_pins();
        rd_chk(ADDR_STATUS_SEC);
        wr(ADDR_MASK_SEC, 8'h00);
        chk_pins();
        $display("test masks done");
        wr(ADDR_PIN_FUNC, {6'h0, FUNC_THERMAL});
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_PIN_BOOST, k[1] ? 8'h06 : 8'h04);
            i_fans_running = k[0];
            hold = 1'b1;
            settle(60);
            compare("boost", {7'h0, k == 3}, {7'h0, o_fan_boost});
            compare("fan full", {7'h0, k == 3}, {7'h0, o_fan_full});
            hold = 1'b0;
            settle(60);
            compare("boost", 8'h00, {7'h0, o_fan_boost});
        end
        i_tach_stall = 4'h8;
        timer_hit = 1'b1;
        settle(2);
        rd_chk(ADDR_STATUS_SEC);
        timer_hit = 1'b0;
        settle(2);
        rd_chk(ADDR_STATUS_SEC);
        i_tach_stall = 4'h0;
        $display("test boost done");
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_PIN_FUNC, k[0] ? 8'h05 : 8'h01);
            i_latch_sel_two = k[0];
            i_latch_temp = {lim(), 2'b00};
            settle(3);
            chk_pins();
            i_latch_temp = {lim(), 2'b01};
            settle(3);
            chk_pins();
            compare("fan full", {7'h0, k == 0}, {7'h0, o_fan_full});
            i_latch_temp = {lim(), 2'b00} - 10'h001;
            settle(3);
            chk_pins();
            rd_chk(ADDR_STATUS_SEC);
            settle(3);
            chk_pins();
        end
        $display("test latch done");
        print_verdict();
    end
endmodule : thermal_alert_status_unit_bench
